// ### design/dadc_channel.sv
// One converter channel: state decode, edge capture and result pipeline.
// Assumes the sample clock and pins are synchronous to ref_clk and slower
// than half its rate, so each high phase lasts at least one ref_clk cycle.
`timescale 1ns/1ns
module dadc_channel #(
   parameter int LATENCY = dadc_pkg::LATENCY
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sample_clock,
   input wire dadc_pkg::dadc_sample_type raw_sample,
   input wire logic powerdown_select,
   input wire logic output_enable_n,
   output dadc_pkg::dadc_chan_mode_type mode,
   output logic drive,
   output dadc_pkg::dadc_sample_type result,
   output logic result_strobe
);

   dadc_pkg::dadc_chan_mode_type mode_r;
   dadc_pkg::dadc_chan_mode_type mode_nxt;
   dadc_pkg::dadc_sample_type pipe_r [LATENCY];
   dadc_pkg::dadc_sample_type result_r;
   logic prev_clk_r;
   logic strobe_r;
   logic rise;
   logic converting;

   // The two select pins pick one of four operating states.
   always_comb begin
      unique case ({powerdown_select, output_enable_n})
         2'b00: mode_nxt = dadc_pkg::CH_NORMAL_DRIVE;
         2'b01: mode_nxt = dadc_pkg::CH_NORMAL_HIZ;
         2'b10: mode_nxt = dadc_pkg::CH_NAP;
         2'b11: mode_nxt = dadc_pkg::CH_SLEEP;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mode_r <= dadc_pkg::CH_SLEEP;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Only this channel's own clock starts its samples.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         prev_clk_r <= 1'b0;
      end else begin
         prev_clk_r <= sample_clock;
      end
   end
   assign rise = sample_clock & ~prev_clk_r;
   assign converting = (mode_r == dadc_pkg::CH_NORMAL_DRIVE) ||
                       (mode_r == dadc_pkg::CH_NORMAL_HIZ);

   // Each rising edge moves every sample one stage on; a result leaves the
   // last stage on the fifth edge after its capture. Nap keeps the stages,
   // sleep empties them, trading a clean restart for lost old samples.
   always_ff @(posedge ref_clk) begin
      if (rst || mode_r == dadc_pkg::CH_SLEEP) begin
         for (int i = 0; i < LATENCY; i++) begin
            pipe_r[i] <= '0;
         end
         result_r <= '0;
         strobe_r <= 1'b0;
      end else if (rise && converting) begin
         pipe_r[0] <= raw_sample;
         for (int i = 1; i < LATENCY; i++) begin
            pipe_r[i] <= pipe_r[i-1];
         end
         result_r <= pipe_r[LATENCY-1];
         strobe_r <= 1'b1;
      end else begin
         strobe_r <= 1'b0;
      end
   end

   assign mode = mode_r;
   assign drive = (mode_r == dadc_pkg::CH_NORMAL_DRIVE);
   assign result = result_r;
   assign result_strobe = strobe_r;

endmodule : dadc_channel

// ### design/dadc_pkg.sv
// Shared constants, types and decode helpers for the dual converter port.
// Assumes every user sits in the single ref_clk domain.
package dadc_pkg;

   // Sample word shape and conversion latency in sample-clock edges.
   localparam int WORD_W = 14;
   localparam int LATENCY = 5;
   localparam int CNT_W = 16;

   // Register port widths and word offsets.
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h2;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h3;
   localparam logic [ADDR_W-1:0] REG_LAST_A = 4'h4;
   localparam logic [ADDR_W-1:0] REG_LAST_B = 4'h5;
   localparam logic [ADDR_W-1:0] REG_OVR_CNT_A = 4'h6;
   localparam logic [ADDR_W-1:0] REG_OVR_CNT_B = 4'h7;

   // Field positions.
   localparam int CTRL_OVERRIDE_BIT = 0;
   localparam int CTRL_LEVEL_LSB = 1;
   localparam int STAT_LEVEL_LSB = 0;
   localparam int STAT_TWOS_BIT = 2;
   localparam int STAT_STAB_BIT = 3;
   localparam int STAT_MODE_A_LSB = 4;
   localparam int STAT_MODE_B_LSB = 6;
   localparam int STAT_SWAP_BIT = 8;
   localparam int IRQ_OVR_A_BIT = 0;
   localparam int IRQ_OVR_B_BIT = 1;
   localparam int IRQ_LEVEL_BIT = 2;
   localparam int IRQ_W = 3;

   // Values after reset.
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;

   // Four levels of the shared format pin, ground upward.
   typedef enum logic [1:0] {
      LVL_GND, LVL_THIRD, LVL_TWO_THIRDS, LVL_FULL
   } dadc_level_type;

   // Operating state of one channel.
   typedef enum logic [1:0] {
      CH_NORMAL_DRIVE, CH_NORMAL_HIZ, CH_NAP, CH_SLEEP
   } dadc_chan_mode_type;

   typedef struct packed {
      logic over;
      logic [WORD_W-1:0] word;
   } dadc_sample_type;

   typedef struct packed {
      logic twos;
      logic stab;
   } dadc_format_type;

   // Level to coding and stabiliser setting; one answer for both channels.
   function automatic dadc_format_type dadc_decode_level(dadc_level_type l);
      dadc_format_type f;
      f = '{twos: 1'b0, stab: 1'b0};
      unique case (l)
         LVL_GND: f = '{twos: 1'b0, stab: 1'b0};
         LVL_THIRD: f = '{twos: 1'b0, stab: 1'b1};
         LVL_TWO_THIRDS: f = '{twos: 1'b1, stab: 1'b1};
         LVL_FULL: f = '{twos: 1'b1, stab: 1'b0};
      endcase
      return f;
   endfunction : dadc_decode_level

endpackage : dadc_pkg

// ### design/dadc_top.sv
// Top of the dual converter output port: two channels, bus swap, shared
// format decode, register port and one level interrupt.
// Assumes all pins and the register port are synchronous to ref_clk and
// that a register master never raises both strobes in one cycle.
`timescale 1ns/1ns
module dadc_top #(
   parameter int WORD_W = dadc_pkg::WORD_W,
   parameter int LATENCY = dadc_pkg::LATENCY
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chan_a_sample_clock,
   input wire logic chan_b_sample_clock,
   input wire logic [WORD_W-1:0] chan_a_raw_code,
   input wire logic chan_a_raw_over,
   input wire logic [WORD_W-1:0] chan_b_raw_code,
   input wire logic chan_b_raw_over,
   input wire logic output_bus_swap_select,
   input wire logic chan_a_powerdown_select,
   input wire logic chan_b_powerdown_select,
   input wire logic chan_a_output_enable_n,
   input wire logic chan_b_output_enable_n,
   input wire logic [1:0] format_select_level,
   input wire logic [dadc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dadc_pkg::DATA_W-1:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [dadc_pkg::DATA_W-1:0] reg_rd_data,
   output logic irq,
   output logic [WORD_W-1:0] bus_a_sample_word,
   output logic bus_a_range_flag,
   output logic bus_a_oe,
   output logic [WORD_W-1:0] bus_b_sample_word,
   output logic bus_b_range_flag,
   output logic bus_b_oe,
   output logic stabiliser_on
);

   dadc_pkg::dadc_sample_type raw_a;
   dadc_pkg::dadc_sample_type raw_b;
   dadc_pkg::dadc_sample_type res_a;
   dadc_pkg::dadc_sample_type res_b;
   dadc_pkg::dadc_sample_type fmt_a;
   dadc_pkg::dadc_sample_type fmt_b;
   dadc_pkg::dadc_sample_type bus_a_nxt;
   dadc_pkg::dadc_sample_type bus_b_nxt;
   dadc_pkg::dadc_sample_type bus_a_r;
   dadc_pkg::dadc_sample_type bus_b_r;
   dadc_pkg::dadc_sample_type last_a_r;
   dadc_pkg::dadc_sample_type last_b_r;
   dadc_pkg::dadc_chan_mode_type mode_a;
   dadc_pkg::dadc_chan_mode_type mode_b;
   dadc_pkg::dadc_level_type level_eff;
   dadc_pkg::dadc_level_type level_prev_r;
   dadc_pkg::dadc_format_type fmt;
   dadc_pkg::dadc_format_type fmt_r;
   logic drive_a;
   logic drive_b;
   logic strobe_a;
   logic strobe_b;
   logic bus_a_oe_nxt;
   logic bus_b_oe_nxt;
   logic bus_a_oe_r;
   logic bus_b_oe_r;
   logic swap_r;
   logic [2:0] ctrl_r;
   logic [dadc_pkg::IRQ_W-1:0] irq_stat_r;
   logic [dadc_pkg::IRQ_W-1:0] irq_stat_nxt;
   logic [dadc_pkg::IRQ_W-1:0] irq_mask_r;
   logic [dadc_pkg::IRQ_W-1:0] irq_event;
   logic [dadc_pkg::IRQ_W-1:0] irq_clear;
   logic irq_r;
   logic [dadc_pkg::CNT_W-1:0] ovr_cnt_a_r;
   logic [dadc_pkg::CNT_W-1:0] ovr_cnt_b_r;
   logic [dadc_pkg::DATA_W-1:0] rd_nxt;
   logic [dadc_pkg::DATA_W-1:0] rd_data_r;
   logic wr_ctrl;
   logic wr_irq_stat;
   logic wr_irq_mask;

   // Pack the quantizer results of each channel.
   assign raw_a = '{over: chan_a_raw_over, word: chan_a_raw_code};
   assign raw_b = '{over: chan_b_raw_over, word: chan_b_raw_code};

   // Both channels are the same logic; only their pins differ.
   dadc_channel #(
      .LATENCY(LATENCY)
   ) u_chan_a (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_clock(chan_a_sample_clock),
      .raw_sample(raw_a),
      .powerdown_select(chan_a_powerdown_select),
      .output_enable_n(chan_a_output_enable_n),
      .mode(mode_a),
      .drive(drive_a),
      .result(res_a),
      .result_strobe(strobe_a)
   );

   dadc_channel #(
      .LATENCY(LATENCY)
   ) u_chan_b (
      .ref_clk(ref_clk),
      .rst(rst),
      .sample_clock(chan_b_sample_clock),
      .raw_sample(raw_b),
      .powerdown_select(chan_b_powerdown_select),
      .output_enable_n(chan_b_output_enable_n),
      .mode(mode_b),
      .drive(drive_b),
      .result(res_b),
      .result_strobe(strobe_b)
   );

   // Software may take the format level over from the pin, which helps
   // when the pin is strapped on the board and a test needs another code.
   assign level_eff = ctrl_r[dadc_pkg::CTRL_OVERRIDE_BIT] ?
      dadc_pkg::dadc_level_type'(ctrl_r[dadc_pkg::CTRL_LEVEL_LSB +: 2]) :
      dadc_pkg::dadc_level_type'(format_select_level);
   assign fmt = dadc_pkg::dadc_decode_level(level_eff);

   // One decoded setting feeds both channels, never one alone.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fmt_r <= '{twos: 1'b0, stab: 1'b0};
         level_prev_r <= dadc_pkg::LVL_GND;
      end else begin
         fmt_r <= fmt;
         level_prev_r <= level_eff;
      end
   end

   // Coding is applied at the output so stored stages stay offset binary.
   always_comb begin
      fmt_a = res_a;
      fmt_b = res_b;
      fmt_a.word[WORD_W-1] = res_a.word[WORD_W-1] ^ fmt_r.twos;
      fmt_b.word[WORD_W-1] = res_b.word[WORD_W-1] ^ fmt_r.twos;
   end

   // Route channels to buses. The enable of a bus follows the channel
   // routed onto it, so swapping also swaps which pin group can float.
   always_comb begin
      if (output_bus_swap_select) begin
         bus_a_nxt = fmt_a;
         bus_b_nxt = fmt_b;
         bus_a_oe_nxt = drive_a;
         bus_b_oe_nxt = drive_b;
      end else begin
         bus_a_nxt = fmt_b;
         bus_b_nxt = fmt_a;
         bus_a_oe_nxt = drive_b;
         bus_b_oe_nxt = drive_a;
      end
   end

   // Bus flops follow the selector every cycle with no extra state, which
   // is what lets one shared signal interleave both channels on one bus.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         bus_a_r <= '0;
         bus_b_r <= '0;
         bus_a_oe_r <= 1'b0;
         bus_b_oe_r <= 1'b0;
         swap_r <= 1'b0;
      end else begin
         bus_a_r <= bus_a_oe_nxt ? bus_a_nxt : '0;
         bus_b_r <= bus_b_oe_nxt ? bus_b_nxt : '0;
         bus_a_oe_r <= bus_a_oe_nxt;
         bus_b_oe_r <= bus_b_oe_nxt;
         swap_r <= output_bus_swap_select;
      end
   end

   // Latest formatted result of each channel, routed or not.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         last_a_r <= '0;
         last_b_r <= '0;
      end else begin
         if (strobe_a) begin
            last_a_r <= fmt_a;
         end
         if (strobe_b) begin
            last_b_r <= fmt_b;
         end
      end
   end

   // Out-of-range result counters stop at full scale instead of wrapping,
   // so a reading of all ones means at least that many.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr_cnt_a_r <= '0;
         ovr_cnt_b_r <= '0;
      end else begin
         if (strobe_a && res_a.over && !(&ovr_cnt_a_r)) begin
            ovr_cnt_a_r <= ovr_cnt_a_r + 1'b1;
         end
         if (strobe_b && res_b.over && !(&ovr_cnt_b_r)) begin
            ovr_cnt_b_r <= ovr_cnt_b_r + 1'b1;
         end
      end
   end

   // Write decodes.
   assign wr_ctrl = reg_wr && (reg_addr == dadc_pkg::REG_CTRL);
   assign wr_irq_stat = reg_wr && (reg_addr == dadc_pkg::REG_IRQ_STAT);
   assign wr_irq_mask = reg_wr && (reg_addr == dadc_pkg::REG_IRQ_MASK);

   // Control register.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_r <= dadc_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wr_data[2:0];
      end
   end

   // Events: an out-of-range result per channel and a format level change.
   always_comb begin
      irq_event = '0;
      irq_event[dadc_pkg::IRQ_OVR_A_BIT] = strobe_a & res_a.over;
      irq_event[dadc_pkg::IRQ_OVR_B_BIT] = strobe_b & res_b.over;
      irq_event[dadc_pkg::IRQ_LEVEL_BIT] = (level_eff != level_prev_r);
   end

   // Write one to clear; a new event in the same cycle keeps its bit set.
   assign irq_clear = wr_irq_stat ? reg_wr_data[dadc_pkg::IRQ_W-1:0] : '0;
   assign irq_stat_nxt = (irq_stat_r & ~irq_clear) | irq_event;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_stat_r <= dadc_pkg::IRQ_RST;
      end else begin
         irq_stat_r <= irq_stat_nxt;
      end
   end

   // Interrupt mask.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_mask_r <= dadc_pkg::IRQ_RST;
      end else if (wr_irq_mask) begin
         irq_mask_r <= reg_wr_data[dadc_pkg::IRQ_W-1:0];
      end
   end

   // The level output is taken from the next status value so it rises in
   // the same cycle as the sticky bit it reports.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // Read multiplexer; unmapped offsets read zero.
   always_comb begin
      rd_nxt = '0;
      unique case (reg_addr)
         dadc_pkg::REG_CTRL: rd_nxt[2:0] = ctrl_r;
         dadc_pkg::REG_STATUS: begin
            rd_nxt[dadc_pkg::STAT_LEVEL_LSB +: 2] = level_eff;
            rd_nxt[dadc_pkg::STAT_TWOS_BIT] = fmt_r.twos;
            rd_nxt[dadc_pkg::STAT_STAB_BIT] = fmt_r.stab;
            rd_nxt[dadc_pkg::STAT_MODE_A_LSB +: 2] = mode_a;
            rd_nxt[dadc_pkg::STAT_MODE_B_LSB +: 2] = mode_b;
            rd_nxt[dadc_pkg::STAT_SWAP_BIT] = swap_r;
         end
         dadc_pkg::REG_IRQ_STAT: rd_nxt[dadc_pkg::IRQ_W-1:0] = irq_stat_r;
         dadc_pkg::REG_IRQ_MASK: rd_nxt[dadc_pkg::IRQ_W-1:0] = irq_mask_r;
         dadc_pkg::REG_LAST_A: rd_nxt[WORD_W:0] = last_a_r;
         dadc_pkg::REG_LAST_B: rd_nxt[WORD_W:0] = last_b_r;
         dadc_pkg::REG_OVR_CNT_A: rd_nxt[dadc_pkg::CNT_W-1:0] = ovr_cnt_a_r;
         dadc_pkg::REG_OVR_CNT_B: rd_nxt[dadc_pkg::CNT_W-1:0] = ovr_cnt_b_r;
         default: rd_nxt = '0;
      endcase
   end

   // Read data stands for exactly the cycle after the strobe.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rd_data_r <= '0;
      end else begin
         rd_data_r <= reg_rd ? rd_nxt : '0;
      end
   end

   // Outputs straight from flops; bit 13 of each word is the MSB.
   assign bus_a_sample_word = bus_a_r.word;
   assign bus_a_range_flag = bus_a_r.over;
   assign bus_a_oe = bus_a_oe_r;
   assign bus_b_sample_word = bus_b_r.word;
   assign bus_b_range_flag = bus_b_r.over;
   assign bus_b_oe = bus_b_oe_r;
   assign stabiliser_on = fmt_r.stab;
   assign reg_rd_data = rd_data_r;
   assign irq = irq_r;

endmodule : dadc_top

// ### sim/dadc_capture_model.sv
// Far-side capture logic: counts each cycle in which either bus drives a word.
// Assumes words are valid at ref_clk edges while a bus enable is high.
`timescale 1ns/1ns
module dadc_capture_model (
   input wire logic ref_clk,
   input wire logic oe_a,
   input wire logic oe_b,
   output logic [15:0] taken
);
   initial taken = 16'h0;
   // Undriven buses carry nothing, so only enabled cycles are counted.
   always @(posedge ref_clk) begin
      if (oe_a || oe_b) begin
         taken <= taken + 16'h1;
      end
   end
endmodule : dadc_capture_model

// ### sim/dadc_tb_top.sv
// Self-checking bench for dadc_top with a queue model of both channels.
// Assumes 20 MHz ref_clk; sample clocks run at one eighth of it.
`timescale 1ns/1ns
module dadc_tb_top;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic sclk [2];
   logic pd [2];
   logic oen [2];
   logic over [2];
   logic [dadc_pkg::WORD_W-1:0] code [2];
   logic swap;
   logic [1:0] lvl;
   logic [3:0] reg_addr;
   logic [31:0] reg_wr_data;
   logic reg_wr;
   logic reg_rd;
   logic [31:0] reg_rd_data;
   logic irq;
   logic [13:0] word_a;
   logic [13:0] word_b;
   logic flag_a;
   logic flag_b;
   logic oe_a;
   logic oe_b;
   logic stab;
   logic [15:0] taken;
   int q [2][$];
   int res [2];
   int due [2];
   int ovr [2];
   logic prev [2];
   int seed = 32'h99A33E93;
   int mismatches = 0;
   int checks = 0;
   int cyc = 0;
   bit quiet = 0;
   bit tie = 0;
   logic [31:0] d;

   always #25 ref_clk = ~ref_clk;

   dadc_top i_dadc_top (.ref_clk(ref_clk), .rst(rst),
      .chan_a_sample_clock(sclk[0]), .chan_b_sample_clock(sclk[1]),
      .chan_a_raw_code(code[0]), .chan_a_raw_over(over[0]),
      .chan_b_raw_code(code[1]), .chan_b_raw_over(over[1]),
      .output_bus_swap_select(swap),
      .chan_a_powerdown_select(pd[0]), .chan_b_powerdown_select(pd[1]),
      .chan_a_output_enable_n(oen[0]), .chan_b_output_enable_n(oen[1]),
      .format_select_level(lvl), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rd_data(reg_rd_data), .irq(irq),
      .bus_a_sample_word(word_a), .bus_a_range_flag(flag_a),
      .bus_a_oe(oe_a), .bus_b_sample_word(word_b),
      .bus_b_range_flag(flag_b), .bus_b_oe(oe_b), .stabiliser_on(stab));

   dadc_capture_model i_dadc_capture_model (.ref_clk(ref_clk),
      .oe_a(oe_a), .oe_b(oe_b), .taken(taken));

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   // Configuration word: level, swap and the pin pair of each channel.
   task automatic apply(input logic [31:0] v);
      lvl <= v[1:0];
      swap <= v[2];
      pd[0] <= v[4];
      oen[0] <= v[3];
      pd[1] <= ~v[4] ^ v[5];
      oen[1] <= ~v[3];
   endtask : apply

   // Configuration pins change at k == 4, in the low phase of both sample clocks; with tie set, swap follows the clocks.
   task automatic run_periods(input int n, input int cfg);
      for (int p = 0; p < n; p++) begin
         for (int k = 0; k < 8; k++) begin
            @(posedge ref_clk);
            sclk[0] <= tie ? (k < 4) : (k < 2);
            sclk[1] <= tie ? (k < 4) : (k == 1 || k == 2);
            for (int c = 0; c < 2; c++) begin
               code[c] <= 14'($random(seed));
               over[c] <= !quiet && (($random(seed) & 7) == 0);
            end
            if (k == 4) apply(cfg >= 32 ? $random(seed) : cfg);
            else if (tie) swap <= (k < 4);
         end
      end
   endtask : run_periods

   task automatic reg_write(input logic [3:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wr_data <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : reg_write

   // Read data is taken in the single cycle after the strobe.
   task automatic reg_read(input logic [3:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(negedge ref_clk);
      v = reg_rd_data;
   endtask : reg_read

   function automatic logic [31:0] status(input logic [1:0] l);
      return {23'h0, swap, pd[1], oen[1], pd[0], oen[0],
              l == 2'h1 || l == 2'h2, l[1], l};
   endfunction : status

   // Channel model: one result leaves per sample edge while not powered down, five edges late.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         wrap_up;
      end
      for (int c = 0; c < 2; c++) begin
         if (due[c] > 0) due[c]--;
         if (rst || (pd[c] && oen[c])) begin
            q[c] = '{0, 0, 0, 0, 0};
            res[c] = 0;
         end
         if (!rst && sclk[c] && !prev[c]) begin
            due[c] = 2;
            if (!pd[c]) begin
               q[c].push_back({over[c], code[c]});
               res[c] = q[c].pop_front();
               if (res[c][14]) ovr[c]++;
            end
         end
         prev[c] = rst ? 1'b0 : sclk[c];
      end
   end

   // Routed result, formatted, one ref_clk after its sample edge.
   always @(negedge ref_clk) begin
      for (int c = 0; c < 2; c++) begin
         if (due[c] == 1) begin
            automatic int x = swap ? c : 1 - c;
            automatic bit en = !pd[c] && !oen[c];
            automatic int e = en ? (32'h8000 | res[c] ^ (lvl[1] << 13)) : 0;
            automatic logic [15:0] g = x ? {oe_b, flag_b, word_b} :
                                           {oe_a, flag_a, word_a};
            check(x ? "bus b" : "bus a", e, g);
            check("stabiliser", lvl == 2'h1 || lvl == 2'h2, stab);
         end
      end
   end

   initial begin
      for (int c = 0; c < 2; c++) begin
         sclk[c] = 1'b0;
         over[c] = 1'b0;
         code[c] = 14'h0;
         due[c] = 0;
         ovr[c] = 0;
         prev[c] = 1'b0;
      end
      apply(32'h0);
      reg_addr = 4'h0;
      reg_wr_data = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      for (int i = 0; i < 32; i++) run_periods(2, i);
      $display("test mode table done");
      run_periods(40, 32);
      $display("test random traffic done");
      quiet = 1;
      run_periods(7, 1);
      reg_read(dadc_pkg::REG_LAST_A, d);
      check("last result a", res[0], d);
      reg_read(dadc_pkg::REG_OVR_CNT_A, d);
      check("overflow count a", ovr[0] > 65535 ? 65535 : ovr[0], d);
      reg_read(dadc_pkg::REG_STATUS, d);
      check("status", status(2'h1), d);
      reg_write(dadc_pkg::REG_IRQ_MASK, 32'h1);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("irq raised", ovr[0] > 0, irq);
      reg_read(dadc_pkg::REG_IRQ_STAT, d);
      check("irq status a", ovr[0] > 0, d[0]);
      reg_write(dadc_pkg::REG_IRQ_STAT, 32'h7);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      check("irq cleared", 32'h0, irq);
      reg_write(dadc_pkg::REG_IRQ_MASK, 32'h0);
      reg_read(4'hF, d);
      check("unmapped", 32'h0, d);
      $display("test registers done");
      reg_write(dadc_pkg::REG_CTRL, 32'h7);
      repeat (4) @(posedge ref_clk);
      reg_read(dadc_pkg::REG_STATUS, d);
      check("override status", status(2'h3), d);
      check("override stabiliser", 32'h0, stab);
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      reg_read(dadc_pkg::REG_CTRL, d);
      check("control after reset", 32'h0, d);
      run_periods(7, 2);
      tie = 1;
      run_periods(7, 24);
      check("partner saw words", 32'h1, taken != 16'h0);
      $display("test override and reset done");
      wrap_up;
   end
endmodule : dadc_tb_top

// ### sim/dadc_top_assertions.sv
// Checker for the dual converter output port, bound to dadc_top.
// Assumes a single ref_clk domain and watches only the top ports.
`timescale 1ns/1ns
module dadc_top_checker #(
   parameter int WORD_W = dadc_pkg::WORD_W,
   parameter int LATENCY = dadc_pkg::LATENCY
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic chan_a_sample_clock,
   input wire logic chan_b_sample_clock,
   input wire logic [WORD_W-1:0] chan_a_raw_code,
   input wire logic chan_a_raw_over,
   input wire logic [WORD_W-1:0] chan_b_raw_code,
   input wire logic chan_b_raw_over,
   input wire logic output_bus_swap_select,
   input wire logic chan_a_powerdown_select,
   input wire logic chan_b_powerdown_select,
   input wire logic chan_a_output_enable_n,
   input wire logic chan_b_output_enable_n,
   input wire logic [1:0] format_select_level,
   input wire logic [dadc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [dadc_pkg::DATA_W-1:0] reg_wr_data,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [dadc_pkg::DATA_W-1:0] reg_rd_data,
   input wire logic irq,
   input wire logic [WORD_W-1:0] bus_a_sample_word,
   input wire logic bus_a_range_flag,
   input wire logic bus_a_oe,
   input wire logic [WORD_W-1:0] bus_b_sample_word,
   input wire logic bus_b_range_flag,
   input wire logic bus_b_oe,
   input wire logic stabiliser_on
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   logic [1:0] age_r;
   logic ovr_en_r;
   logic [1:0] ovr_lvl_r;
   // Age keeps the zeroed first edges after reset out of the checks.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         age_r <= 2'h0;
      end else if (age_r != 2'h3) begin
         age_r <= age_r + 2'h1;
      end
   end
   // Shadow of the level override, so the stabiliser check follows it.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ovr_en_r <= 1'b0;
         ovr_lvl_r <= 2'h0;
      end else if (reg_wr && reg_addr == dadc_pkg::REG_CTRL) begin
         ovr_en_r <= reg_wr_data[0];
         ovr_lvl_r <= reg_wr_data[2:1];
      end
   end
   // Pin drive condition of each channel. The channel registers its mode
   // first, so a bus enable sees the pins two edges late, the swap one.
   wire settled = age_r == 2'h3;
   wire [1:0] eff = ovr_en_r ? ovr_lvl_r : format_select_level;
   wire drv_a = !chan_a_powerdown_select && !chan_a_output_enable_n;
   wire drv_b = !chan_b_powerdown_select && !chan_b_output_enable_n;
   property p_oe_a;
      settled |-> bus_a_oe == ($past(output_bus_swap_select) ?
         $past(drv_a, 2) : $past(drv_b, 2));
   endproperty
   a_oe_a: assert property (p_oe_a)
      else $error("bus a enable wrong");
   property p_oe_b;
      settled |-> bus_b_oe == ($past(output_bus_swap_select) ?
         $past(drv_b, 2) : $past(drv_a, 2));
   endproperty
   a_oe_b: assert property (p_oe_b)
      else $error("bus b enable wrong");
   property p_off_a;
      !bus_a_oe |-> bus_a_sample_word == '0 && !bus_a_range_flag;
   endproperty
   a_off_a: assert property (p_off_a) else $error("bus a not idle");
   property p_off_b;
      !bus_b_oe |-> bus_b_sample_word == '0 && !bus_b_range_flag;
   endproperty
   a_off_b: assert property (p_off_b) else $error("bus b not idle");
   property p_stab;
      settled && eff == $past(eff) && eff == $past(eff, 2)
         && eff == $past(eff, 3)
         |-> stabiliser_on == (eff == 2'h1 || eff == 2'h2);
   endproperty
   a_stab: assert property (p_stab) else $error("stabiliser wrong");
   property p_rd_idle;
      settled && !$past(reg_rd) |-> reg_rd_data == '0;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_unmapped;
      reg_rd && reg_addr > dadc_pkg::REG_OVR_CNT_B |=> reg_rd_data == '0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read");
   property p_mask_off;
      reg_wr && reg_addr == dadc_pkg::REG_IRQ_MASK && reg_wr_data[2:0] == 3'h0
         |-> ##2 !irq;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("irq not masked");
   c_swap: cover property ($fell(output_bus_swap_select));
   c_irq: cover property ($rose(irq));
   c_oe_off: cover property ($fell(bus_a_oe));
endmodule : dadc_top_checker

bind dadc_top dadc_top_checker #(.WORD_W(WORD_W), .LATENCY(LATENCY))
   i_chk (.*);
